// [rtl/sdi_idle_pkg.sv]
// Package: constants and types for the idle character and status registers
package sdi_idle_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] SDI_OFS_IDLE_LOW = 8'h0D;
    localparam logic [7:0] SDI_OFS_IDLE_HIGH = 8'h0E;
    localparam logic [7:0] SDI_OFS_STATUS = 8'h1D;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int SDI_IDLE_W = 10;
    localparam int SDI_HIGH_LSB = 8;
    localparam int SDI_ST_LOOP_BIT = 5;
    localparam int SDI_ST_MODE_LSB = 3;
    localparam int SDI_ST_PART_LSB = 0;
    // K28.5 with running disparity negative
    localparam logic [9:0] SDI_IDLE_RST = 10'h17C;
    localparam logic [1:0] SDI_MODE_ASI = 2'h3;
    // Part-type code: value is arbitrary
    localparam logic [1:0] SDI_PART_CODE = 2'h2;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sdi_reg_req_t;

    typedef struct packed {
        logic [9:0] idle_char;
        logic loop_en;
        logic [1:0] mode;
        logic [7:0] rdata;
        logic [9:0] data_out;
    } sdi_state_t;

endpackage : sdi_idle_pkg

// [rtl/sdi_idle_regs.sv]
// Module: idle character insertion and status readback registers
`timescale 1ns/1ns
module sdi_idle_regs #(
    parameter logic [1:0] PART_CODE = sdi_idle_pkg::SDI_PART_CODE
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire sdi_idle_pkg::sdi_reg_req_t req_i,
    output logic [7:0] rdata_o,
    input wire logic [9:0] rx_data_i,
    input wire logic rx_valid_i,
    input wire logic [1:0] mode_i,
    input wire logic loop_en_i,
    output logic [9:0] data_o,
    output logic [9:0] idle_char_o
);
    import sdi_idle_pkg::*;

    sdi_state_t state_reg;
    sdi_state_t state_next;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [7:0] st;
        st = 8'h00;
        state_next = state_reg;
        if (req_i.wr) begin
            if (req_i.addr == SDI_OFS_IDLE_LOW) begin
                state_next.idle_char[7:0] = req_i.wdata;
            end
            if (req_i.addr == SDI_OFS_IDLE_HIGH) begin
                // Upper six bits dropped on purpose
                state_next.idle_char[9:8] = req_i.wdata[1:0];
            end
        end
        state_next.loop_en = loop_en_i;
        state_next.mode = mode_i;
        st[SDI_ST_LOOP_BIT] = state_reg.loop_en;
        st[SDI_ST_MODE_LSB +: 2] = state_reg.mode;
        st[SDI_ST_PART_LSB +: 2] = PART_CODE;
        case (req_i.addr)
            SDI_OFS_IDLE_LOW: state_next.rdata = state_reg.idle_char[7:0];
            SDI_OFS_IDLE_HIGH: begin
                state_next.rdata = {6'h00, state_reg.idle_char[9:8]};
            end
            SDI_OFS_STATUS: state_next.rdata = st;
            default: state_next.rdata = 8'h00;
        endcase
        // Idle replaces any word the receiver could not vouch for
        if (rx_valid_i) begin
            state_next.data_out = rx_data_i;
        end else begin
            state_next.data_out = state_reg.idle_char;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state_reg.idle_char <= SDI_IDLE_RST;
            // Synchronous reset, so the pin may be caught here
            state_reg.loop_en <= loop_en_i;
            state_reg.mode <= 2'h0;
            state_reg.rdata <= 8'h00;
            state_reg.data_out <= SDI_IDLE_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata_o = state_reg.rdata;
    assign data_o = state_reg.data_out;
    assign idle_char_o = state_reg.idle_char;

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // The status byte is assembled by position, so overlapping fields
    // would silently corrupt each other
    if (SDI_ST_MODE_LSB + 2 > SDI_ST_LOOP_BIT) begin : g_chk_mode
        $error("mode field overlaps loop bit");
    end
    if (SDI_ST_PART_LSB + 2 > SDI_ST_MODE_LSB) begin : g_chk_part
        $error("part field overlaps mode field");
    end
    if (SDI_IDLE_W != SDI_HIGH_LSB + 2) begin : g_chk_idle
        $error("idle width does not match register pair");
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    AST_IDLE_INSERT: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        !rx_valid_i |=> data_o == $past(idle_char_o))
        else $error("idle not inserted");

    AST_DATA_PASS: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        rx_valid_i |=> data_o == $past(rx_data_i))
        else $error("valid data not forwarded");

    AST_NO_DATA_IDLE: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        !rx_valid_i && !req_i.wr |=> data_o == idle_char_o)
        else $error("output differs from held idle");

    AST_DATA_RESET: assert property (
        @(posedge clk_i)
        !rstn_i |=> data_o == SDI_IDLE_RST)
        else $error("output word not idle after reset");

    AST_IDLE_RESET: assert property (
        @(posedge clk_i)
        !rstn_i |=> idle_char_o == SDI_IDLE_RST)
        else $error("idle reset value wrong");

    AST_IDLE_HOLD: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        !req_i.wr |=> $stable(idle_char_o))
        else $error("idle changed without write");

    AST_IDLE_WRITE: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        req_i.wr && req_i.addr == SDI_OFS_IDLE_HIGH
        |=> idle_char_o[9:8] == $past(req_i.wdata[1:0]))
        else $error("idle high bits not written");

    AST_IDLE_LOW_WRITE: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        req_i.wr && req_i.addr == SDI_OFS_IDLE_LOW
        |=> idle_char_o[7:0] == $past(req_i.wdata))
        else $error("idle low bits not written");

    AST_HIGH_KEEPS_LOW: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        req_i.wr && req_i.addr == SDI_OFS_IDLE_HIGH
        |=> idle_char_o[7:0] == $past(idle_char_o[7:0]))
        else $error("high write disturbed low bits");

    AST_LOW_KEEPS_HIGH: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        req_i.wr && req_i.addr == SDI_OFS_IDLE_LOW
        |=> idle_char_o[9:8] == $past(idle_char_o[9:8]))
        else $error("low write disturbed high bits");

    AST_LOW_READ: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        req_i.addr == SDI_OFS_IDLE_LOW
        |=> rdata_o == $past(idle_char_o[7:0]))
        else $error("idle low readback wrong");

    AST_HIGH_READ: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        req_i.addr == SDI_OFS_IDLE_HIGH
        |=> rdata_o[1:0] == $past(idle_char_o[9:8]))
        else $error("idle high readback wrong");

    // Catches the pin level at the last reset edge, two edges to rdata_o
    AST_LOOP_RESET: assert property (
        @(posedge clk_i)
        !rstn_i ##1 rstn_i && !req_i.wr && req_i.addr == SDI_OFS_STATUS
        |=> rdata_o[SDI_ST_LOOP_BIT] == $past(loop_en_i, 2))
        else $error("loop bit not from pin");

    AST_LOOP_FOLLOW: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        req_i.addr == SDI_OFS_STATUS ##1 req_i.addr == SDI_OFS_STATUS
        |=> rdata_o[SDI_ST_LOOP_BIT] == $past(loop_en_i, 2))
        else $error("loop bit does not follow pin");

    AST_MODE_READ: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        req_i.addr == SDI_OFS_STATUS ##1 req_i.addr == SDI_OFS_STATUS
        |=> rdata_o[SDI_ST_MODE_LSB +: 2] == $past(mode_i, 2))
        else $error("mode field wrong");

    AST_ASI_MODE: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        req_i.addr == SDI_OFS_STATUS && mode_i == SDI_MODE_ASI
        ##1 req_i.addr == SDI_OFS_STATUS
        |=> rdata_o[SDI_ST_MODE_LSB +: 2] == SDI_MODE_ASI)
        else $error("asi mode not reported");

    AST_STD_MODE: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        req_i.addr == SDI_OFS_STATUS && mode_i != SDI_MODE_ASI
        ##1 req_i.addr == SDI_OFS_STATUS
        |=> rdata_o[SDI_ST_MODE_LSB +: 2] != SDI_MODE_ASI)
        else $error("standard mode reported as asi");

    AST_PART_READ: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        req_i.addr == SDI_OFS_STATUS |=> rdata_o[1:0] == PART_CODE)
        else $error("part code wrong");

    AST_PART_FIXED: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        req_i.addr == SDI_OFS_STATUS ##1 req_i.addr == SDI_OFS_STATUS
        |=> $stable(rdata_o[SDI_ST_PART_LSB +: 2]))
        else $error("part code not fixed");

    AST_RSVD_ZERO: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        req_i.addr == SDI_OFS_IDLE_HIGH |=> rdata_o[7:2] == 6'h00)
        else $error("reserved bits nonzero");

    AST_STATUS_RSVD: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        req_i.addr == SDI_OFS_STATUS
        |=> rdata_o[7:6] == 2'h0 && rdata_o[2] == 1'b0)
        else $error("status reserved bits nonzero");

    AST_UNMAPPED_ZERO: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        req_i.addr != SDI_OFS_IDLE_LOW && req_i.addr != SDI_OFS_IDLE_HIGH
        && req_i.addr != SDI_OFS_STATUS |=> rdata_o == 8'h00)
        else $error("unmapped read nonzero");

    // Status and unmapped offsets must never reach the idle storage
    AST_OTHER_WRITE: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        req_i.wr && req_i.addr != SDI_OFS_IDLE_LOW
        && req_i.addr != SDI_OFS_IDLE_HIGH |=> $stable(idle_char_o))
        else $error("stray write changed idle");

    AST_RDATA_RESET: assert property (
        @(posedge clk_i)
        !rstn_i |=> rdata_o == 8'h00)
        else $error("read data not cleared by reset");

endmodule : sdi_idle_regs

// [test/sdi_idle_regs_tb.sv]
// Testbench for the idle character and status registers
`timescale 1ns/1ns
module sdi_idle_regs_tb;
    import sdi_idle_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    sdi_reg_req_t req_i = '0;
    logic [9:0] rx_data_i = 10'h000;
    logic rx_valid_i = 1'b0;
    logic [1:0] mode_i = 2'h0;
    logic loop_en_i = 1'b0;
    logic [7:0] rdata_o;
    logic [9:0] data_o;
    logic [9:0] idle_char_o;
    int n_fail = 0;
    int checks = 0;
    // ------------------------------------------------------------------
    // Rows: addr, wdata, wr, {loop, mode}, expected readback
    // ------------------------------------------------------------------
    logic [7:0] rows [8][5] = '{'{8'h0D, 8'hAA, 8'h01, 8'h00, 8'hAA},
        '{8'h0E, 8'hFF, 8'h01, 8'h00, 8'h03},
        '{8'h1D, 8'hFF, 8'h01, 8'h07, 8'h3A},
        '{8'h1D, 8'h00, 8'h00, 8'h00, 8'h02},
        '{8'h1D, 8'h00, 8'h00, 8'h01, 8'h0A},
        '{8'h1D, 8'h00, 8'h00, 8'h02, 8'h12},
        '{8'h33, 8'hFF, 8'h01, 8'h00, 8'h00},
        '{8'h0D, 8'h00, 8'h00, 8'h00, 8'hAA}};
    sdi_idle_regs u_sdi_idle_regs (.clk_i(clk_i), .rstn_i(rstn_i),
        .req_i(req_i), .rdata_o(rdata_o), .rx_data_i(rx_data_i),
        .rx_valid_i(rx_valid_i), .mode_i(mode_i), .loop_en_i(loop_en_i),
        .data_o(data_o), .idle_char_o(idle_char_o));
    initial forever #4 clk_i = ~clk_i;
    task chk(input logic [9:0] got, input logic [9:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Two edges: the write lands on the first, readback on the second
    task access(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        req_i.wr = wr;
        req_i.addr = a;
        req_i.wdata = d;
        @(negedge clk_i);
        req_i.wr = 1'b0;
        @(negedge clk_i);
    endtask : access
    task tally_and_finish;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (5) @(negedge clk_i);
        rstn_i = 1'b1;
        chk(idle_char_o, 10'h17C);
        chk(data_o, 10'h17C);
        for (int i = 0; i < 8; i++) begin
            mode_i = rows[i][3][1:0];
            loop_en_i = rows[i][3][2];
            access(rows[i][2][0], rows[i][0], rows[i][1]);
            chk({2'h0, rdata_o}, {2'h0, rows[i][4]});
        end
        chk(idle_char_o, 10'h3AA);
        chk(data_o, 10'h3AA);
        rx_valid_i = 1'b1;
        rx_data_i = 10'h155;
        @(negedge clk_i);
        chk(data_o, 10'h155);
        rx_valid_i = 1'b0;
        @(negedge clk_i);
        chk(data_o, 10'h3AA);
        // Second reset in mid-run with the loopthrough pin high
        loop_en_i = 1'b1;
        req_i.addr = 8'h1D;
        rstn_i = 1'b0;
        repeat (2) @(negedge clk_i);
        rstn_i = 1'b1;
        chk(idle_char_o, 10'h17C);
        access(1'b0, 8'h1D, 8'h00);
        chk({2'h0, rdata_o}, 10'h022);
        tally_and_finish();
    end
endmodule : sdi_idle_regs_tb
